// >>> core/frg_pkg.sv
// Purpose: Shared constants and types of the frequency ramp generator.
// Assumes: Frequencies in 0.01 Hz units, ramp time in 1 ms ticks.
// Notes: Register word index is the byte offset divided by four.
package frg_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam int FRG_NREG = 13;
   localparam logic [3:0] FRG_IDX_CTRL = 4'h0;
   localparam logic [3:0] FRG_IDX_SETF = 4'h1;
   localparam logic [3:0] FRG_IDX_ACC1 = 4'h2;
   localparam logic [3:0] FRG_IDX_DEC1 = 4'h3;
   localparam logic [3:0] FRG_IDX_ACC2 = 4'h4;
   localparam logic [3:0] FRG_IDX_DEC2 = 4'h5;
   localparam logic [3:0] FRG_IDX_SWF = 4'h6;
   localparam logic [3:0] FRG_IDX_REFF = 4'h7;
   localparam logic [3:0] FRG_IDX_BASEF = 4'h8;
   localparam logic [3:0] FRG_IDX_STARTF = 4'h9;
   localparam logic [3:0] FRG_IDX_HOLD = 4'hA;
   localparam logic [3:0] FRG_IDX_MINF = 4'hB;
   localparam logic [3:0] FRG_IDX_PRESET = 4'hC;
   localparam logic [3:0] FRG_IDX_STATUS = 4'hD;
   localparam int FRG_CTRL_FINE_BIT = 2;
   localparam logic [15:0] FRG_CTRL_MASK = 16'h0007;
   localparam logic [FRG_NREG-1:0][15:0] FRG_CFG_RST = {16'h0000, 16'h0000, 16'h270F, 16'h0032, 16'h1388,
      16'h1388, 16'h270F, 16'h270F, 16'h0032, 16'h0032, 16'h0032, 16'h0000, 16'h0000};
   // ************************************************************
   // Values and limits
   // ************************************************************
   localparam logic [15:0] FRG_DISABLE = 16'h270F;
   localparam logic [15:0] FRG_TIME_MAX = 16'h8CA0;
   localparam logic [15:0] FRG_FREQ_MAX = 16'h9C40;
   localparam logic [15:0] FRG_REF_MIN = 16'h0064;
   localparam logic [15:0] FRG_START_MAX = 16'h1770;
   localparam logic [15:0] FRG_HOLD_MAX = 16'h0064;
   localparam logic [15:0] FRG_HOLD_ZERO_FREQ = 16'h0001;
   localparam logic [1:0] FRG_SHAPE_LIN = 2'h0;
   localparam logic [1:0] FRG_SHAPE_A = 2'h1;
   localparam logic [1:0] FRG_SHAPE_B = 2'h2;
   localparam logic [47:0] FRG_A_NUM = 48'h9;
   localparam logic [47:0] FRG_A_DEN = 48'h8;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int FRG_CLK_PERIOD_NS = 25;
   localparam int FRG_TICK_NS = 1000000;
   localparam int FRG_TICK_CYCLES = FRG_TICK_NS / FRG_CLK_PERIOD_NS;
   localparam logic [23:0] FRG_COARSE_MS = 24'h0064;
   localparam logic [23:0] FRG_FINE_MS = 24'h000A;
   localparam logic [23:0] FRG_TIME_LIM_MS = 24'h001E;
   localparam logic [23:0] FRG_TIME_MIN_MS = 24'h0028;
   localparam logic [13:0] FRG_HOLD_MS = 14'h0064;
   localparam logic [5:0] FRG_DIV_STEPS = 6'h2F;
   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } frg_wb_req_t;
   typedef enum logic [2:0] {
      FRG_STOP = 3'b001,
      FRG_HOLD = 3'b010,
      FRG_RUN = 3'b100
   } frg_run_t;
   typedef struct packed {
      logic [31:0] wb_dat;
      logic wb_ack;
      logic [FRG_NREG-1:0][15:0] cfg;
      logic [23:0] tick_cnt;
      frg_run_t st;
      logic [15:0] freq;
      logic rev;
      logic run;
      logic sec;
      logic [13:0] hold_cnt;
      logic div_busy;
      logic [5:0] div_cnt;
      logic [47:0] div_rem;
      logic [47:0] div_quo;
      logic [47:0] div_den;
      logic [47:0] carry;
      logic [15:0] tgt;
      logic [15:0] seg_start;
   } frg_core_t;
endpackage : frg_pkg

// >>> core/frg_ramp.sv
// Purpose: Output frequency ramp generator with a classic Wishbone register slave.
// Assumes: start, direction and second function inputs are synchronous to core_clk_i.
// Notes: Each run tick off target, with no division busy and no zero target at or below starting frequency, starts a serial division for the per-tick step.
// Operation
// R01: Primary acceleration time is the time from zero to the reference frequency.
// R02: Primary deceleration time is the time from reference frequency down to zero.
// R03: Fine increments reinterpret stored times tenfold smaller; restart time is untouched.
// R04: Secondary times apply on second function select or frequency at switching threshold.
// R05: Secondary deceleration of 9999 reuses the secondary acceleration time.
// R06: Configuring party assigns function code 3 to an input terminal.
// R07: Switching frequency 9999 disables switching; zero selects secondary times from start.
// R08: Without select, primary below threshold and secondary at or above it.
// R09: Second function select switches to secondary times immediately.
// R10: In S-curve A the ramp time refers to the base frequency.
// R11: In S-curve A above base, time follows four ninths square law plus five ninths.
// R12: Ramp times of 0.03 s or less act as 0.04 s.
// R13: Starting frequency 0 to 60 Hz, default 0.5 Hz, output at start.
// R14: No start while the frequency command is below the starting frequency.
// R15: Start hold 0 to 10 s holds the starting frequency; 9999 disables it.
// R16: A zero starting frequency is held at 0.01 Hz during the hold.
// R17: Dropping start during the hold begins deceleration at once.
// R18: Reversal applies the starting frequency but skips the hold.
// R19: Starting frequency at or below minimum lets start alone run the preset frequency.
// R20: Shape select 0 linear, 1 S-curve A, 2 S-curve B, linear default.
// R21: Linear mode changes frequency at a constant rate until the target.
// R22: S-curve B shapes each ramp from present frequency to new target.
// R23: Time increments 0.1 s up to 3600 s or 0.01 s up to 360 s.
// R24: Reference frequency is programmable from 1 to 400 Hz.
// R25: Frequency updates on a periodic tick by a step from reference and time.
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module frg_ramp #(
   parameter int TICK_CYCLES = frg_pkg::FRG_TICK_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire frg_pkg::frg_wb_req_t wb_req_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic start_i,
   input wire logic reverse_i,
   input wire logic second_function_select_i,
   output logic [15:0] current_frequency_o,
   output logic reverse_o,
   output logic running_o,
   output logic second_active_o
);
   import frg_pkg::*;

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [23:0] frg_time_ticks(input logic [15:0] raw, input logic fine);
      logic [23:0] t;
      t = 24'(raw) * (fine ? FRG_FINE_MS : FRG_COARSE_MS); // R03 R23
      if (t <= FRG_TIME_LIM_MS) begin
         t = FRG_TIME_MIN_MS; // R12
      end
      return t;
   endfunction : frg_time_ticks

   function automatic logic [15:0] frg_clamp(input logic [3:0] idx, input logic [15:0] v);
      logic [15:0] r;
      r = v;
      unique case (idx)
         FRG_IDX_CTRL: begin
            r = v & FRG_CTRL_MASK;
         end
         FRG_IDX_ACC1, FRG_IDX_DEC1, FRG_IDX_ACC2, FRG_IDX_DEC2: begin
            r = (v > FRG_TIME_MAX) ? FRG_TIME_MAX : v; // R23
         end
         FRG_IDX_SWF, FRG_IDX_SETF, FRG_IDX_PRESET, FRG_IDX_MINF: begin
            r = (v > FRG_FREQ_MAX) ? FRG_FREQ_MAX : v;
         end
         FRG_IDX_REFF, FRG_IDX_BASEF: begin
            r = (v < FRG_REF_MIN) ? FRG_REF_MIN : ((v > FRG_FREQ_MAX) ? FRG_FREQ_MAX : v); // R24
         end
         FRG_IDX_STARTF: begin
            r = (v > FRG_START_MAX) ? FRG_START_MAX : v; // R13
         end
         FRG_IDX_HOLD: begin
            r = (v > FRG_HOLD_MAX && v != FRG_DISABLE) ? FRG_HOLD_MAX : v; // R15
         end
         default: begin
            r = v;
         end
      endcase
      return r;
   endfunction : frg_clamp

   function automatic logic [15:0] frg_absdiff(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? (a - b) : (b - a);
   endfunction : frg_absdiff

   // ************************************************************
   // State
   // ************************************************************
   localparam frg_core_t FRG_CORE_RST = '{
      wb_dat: 32'h0000_0000, wb_ack: 1'b0, cfg: FRG_CFG_RST, tick_cnt: 24'h00_0000,
      st: FRG_STOP, freq: 16'h0000, rev: 1'b0, run: 1'b0, sec: 1'b0,
      hold_cnt: 14'h0000, div_busy: 1'b0, div_cnt: 6'h00, div_rem: 48'h0,
      div_quo: 48'h0, div_den: 48'h0, carry: 48'h0, tgt: 16'h0000, seg_start: 16'h0000
   };
   localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

   frg_core_t q;
   frg_core_t d;
   logic tick;
   logic [3:0] idx;
   logic [15:0] wr_val;
   logic [1:0] shape;
   logic fine;
   logic [15:0] cmd_eff;
   logic run_ok;
   logic sec;
   logic [15:0] dec2_eff;
   logic [23:0] t_acc;
   logic [23:0] t_dec;
   logic [23:0] t_act;
   logic [15:0] target;
   logic [15:0] span;
   logic [15:0] near;
   logic [47:0] add_w;
   logic [47:0] den_w;
   logic [47:0] rem_s;
   logic [47:0] quo_s;
   logic [15:0] step;
   logic [16:0] up;

   always_comb begin
      d = q;
      tick = (q.tick_cnt >= TICK_LAST);
      d.tick_cnt = tick ? 24'h00_0000 : (q.tick_cnt + 24'h00_0001);

      // ************************************************************
      // Wishbone slave
      // ************************************************************
      idx = wb_req_i.adr[5:2];
      wr_val = q.cfg[idx[3:0] < 4'(FRG_NREG) ? idx : 4'h0];
      if (wb_req_i.sel[0]) begin
         wr_val[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1]) begin
         wr_val[15:8] = wb_req_i.dat[15:8];
      end
      d.wb_ack = 1'b0;
      if (wb_req_i.cyc && wb_req_i.stb && !q.wb_ack) begin
         d.wb_ack = 1'b1;
         d.wb_dat = 32'h0000_0000;
         if (wb_req_i.adr[7:6] == 2'h0 && idx < 4'(FRG_NREG)) begin
            d.wb_dat = {16'h0000, q.cfg[idx]};
            if (wb_req_i.we) begin
               d.cfg[idx] = frg_clamp(idx, wr_val);
            end
         end else if (wb_req_i.adr[7:6] == 2'h0 && idx == FRG_IDX_STATUS) begin
            d.wb_dat = {13'h0000, q.sec, q.rev, q.run, q.freq};
         end
      end

      // ************************************************************
      // Ramp parameters
      // ************************************************************
      shape = q.cfg[FRG_IDX_CTRL][1:0]; // R20
      fine = q.cfg[FRG_IDX_CTRL][FRG_CTRL_FINE_BIT];
      cmd_eff = q.cfg[FRG_IDX_SETF];
      if (q.cfg[FRG_IDX_STARTF] <= q.cfg[FRG_IDX_MINF] && q.cfg[FRG_IDX_SETF] == 16'h0000) begin
         cmd_eff = q.cfg[FRG_IDX_PRESET]; // R19
      end
      run_ok = start_i && (cmd_eff >= q.cfg[FRG_IDX_STARTF]) && (cmd_eff != 16'h0000); // R14
      sec = second_function_select_i || // R09
         (q.cfg[FRG_IDX_SWF] != FRG_DISABLE && q.freq >= q.cfg[FRG_IDX_SWF]); // R04 R07 R08
      dec2_eff = (q.cfg[FRG_IDX_DEC2] == FRG_DISABLE) ? q.cfg[FRG_IDX_ACC2] : q.cfg[FRG_IDX_DEC2]; // R05
      t_acc = frg_time_ticks(sec ? q.cfg[FRG_IDX_ACC2] : q.cfg[FRG_IDX_ACC1], fine); // R01
      t_dec = frg_time_ticks(sec ? dec2_eff : q.cfg[FRG_IDX_DEC1], fine); // R02
      target = (run_ok && q.rev == reverse_i) ? cmd_eff : 16'h0000;
      t_act = (target > q.freq) ? t_acc : t_dec;
      d.sec = sec;
      if (target != q.tgt) begin
         d.tgt = target;
         d.seg_start = q.freq;
      end
      span = frg_absdiff(q.tgt, q.seg_start);
      near = frg_absdiff(q.freq, q.seg_start);
      if (frg_absdiff(q.tgt, q.freq) < near) begin
         near = frg_absdiff(q.tgt, q.freq);
      end
      add_w = 48'(q.cfg[FRG_IDX_REFF]); // R01 R02
      den_w = 48'(t_act);
      if (shape == FRG_SHAPE_A && q.freq < q.cfg[FRG_IDX_BASEF]) begin
         add_w = 48'(q.cfg[FRG_IDX_BASEF]); // R10
      end else if (shape == FRG_SHAPE_A) begin
         add_w = 48'(q.cfg[FRG_IDX_BASEF]) * 48'(q.cfg[FRG_IDX_BASEF]) * FRG_A_NUM; // R11
         den_w = 48'(t_act) * 48'(q.freq) * FRG_A_DEN; // R11
      end else if (shape == FRG_SHAPE_B && span != 16'h0000) begin
         add_w = 48'(q.cfg[FRG_IDX_REFF]) * (48'({near, 1'b0}) + 48'(span[15:2]) + 48'h1); // R22
         den_w = 48'(t_act) * 48'(span); // R22
      end

      // ************************************************************
      // Serial step division
      // ************************************************************
      rem_s = {q.div_rem[46:0], q.div_quo[47]};
      quo_s = {q.div_quo[46:0], 1'b0};
      if (rem_s >= q.div_den) begin
         rem_s = rem_s - q.div_den;
         quo_s[0] = 1'b1;
      end
      step = (|quo_s[47:16]) ? 16'hFFFF : quo_s[15:0];
      up = 17'(q.freq) + 17'(step);

      // ************************************************************
      // Run sequence
      // ************************************************************
      unique case (q.st)
         FRG_STOP: begin
            d.freq = 16'h0000;
            d.run = 1'b0;
            d.div_busy = 1'b0;
            d.carry = 48'h0;
            if (run_ok) begin
               d.run = 1'b1;
               d.rev = reverse_i;
               d.freq = q.cfg[FRG_IDX_STARTF]; // R13
               d.seg_start = q.cfg[FRG_IDX_STARTF];
               d.st = FRG_RUN;
               if (q.cfg[FRG_IDX_HOLD] != FRG_DISABLE && q.cfg[FRG_IDX_HOLD] != 16'h0000) begin
                  d.st = FRG_HOLD; // R15
                  d.hold_cnt = q.cfg[FRG_IDX_HOLD][13:0] * FRG_HOLD_MS;
                  if (q.cfg[FRG_IDX_STARTF] == 16'h0000) begin
                     d.freq = FRG_HOLD_ZERO_FREQ; // R16
                  end
               end
            end
         end
         FRG_HOLD: begin
            if (!start_i || q.rev != reverse_i) begin
               d.st = FRG_RUN; // R17
            end else if (tick) begin
               d.hold_cnt = q.hold_cnt - 14'h0001;
               if (q.hold_cnt <= 14'h0001) begin
                  d.st = FRG_RUN; // R15
               end
            end
         end
         FRG_RUN: begin
            if (target == 16'h0000 && q.freq <= q.cfg[FRG_IDX_STARTF]) begin
               d.div_busy = 1'b0;
               d.carry = 48'h0;
               if (start_i && q.rev != reverse_i && cmd_eff >= q.cfg[FRG_IDX_STARTF] && cmd_eff != 16'h0000) begin
                  d.rev = reverse_i; // R18
                  d.freq = q.cfg[FRG_IDX_STARTF]; // R18
                  d.seg_start = q.cfg[FRG_IDX_STARTF];
               end else begin
                  d.st = FRG_STOP;
                  d.freq = 16'h0000;
                  d.run = 1'b0;
               end
            end else if (q.div_busy) begin
               d.div_rem = rem_s;
               d.div_quo = quo_s;
               d.div_cnt = q.div_cnt - 6'h01;
               if (q.div_cnt == 6'h00) begin
                  d.div_busy = 1'b0;
                  d.carry = rem_s;
                  if (target > q.freq) begin
                     d.freq = (up > 17'(target)) ? target : up[15:0]; // R21 R25
                  end else begin
                     d.freq = (q.freq - target < step) ? target : (q.freq - step); // R21 R25
                  end
               end
            end else if (tick && target != q.freq) begin
               d.div_busy = 1'b1; // R25
               d.div_cnt = FRG_DIV_STEPS;
               d.div_rem = 48'h0;
               d.div_quo = q.carry + add_w;
               d.div_den = den_w;
            end else if (target == q.freq) begin
               d.carry = 48'h0;
            end
         end
         default: begin
            d = FRG_CORE_RST;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= FRG_CORE_RST;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign wb_ack_o = q.wb_ack;
   assign wb_dat_o = q.wb_dat;
   assign current_frequency_o = q.freq;
   assign reverse_o = q.rev;
   assign running_o = q.run;
   assign second_active_o = q.sec;
endmodule : frg_ramp
`default_nettype wire

// >>> verification/frg_ramp_checker.sv
// Purpose: Concurrent checks on the ports of the ramp generator.
// Assumes: One clock domain, asynchronous reset active low.
// Notes: Bound to every frg_ramp instance.
`timescale 1ns/1ps
`default_nettype none
module frg_ramp_checker #(
   parameter int TICK_CYCLES = 100
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire frg_pkg::frg_wb_req_t wb_req_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic start_i,
   input wire logic reverse_i,
   input wire logic second_function_select_i,
   input wire logic [15:0] current_frequency_o,
   input wire logic reverse_o,
   input wire logic running_o,
   input wire logic second_active_o
);
   import frg_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after a request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (!(wb_req_i.cyc && wb_req_i.stb) |=> !wb_ack_o)
      else $error("ack without a request");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:19] == 13'h0000)
      else $error("unused read data bits set");
   a_stop_zero: assert property (!running_o |-> current_frequency_o == 16'h0000)
      else $error("frequency nonzero while stopped");
   a_start_cause: assert property ($rose(running_o) |-> $past(start_i))
      else $error("run began without start");
   a_step_gap: assert property (running_o && $past(running_o) && $changed(current_frequency_o)
      && $stable(reverse_o) |=> (!running_o || $changed(reverse_o) || $stable(current_frequency_o)) [*8])
      else $error("frequency steps too close together");
   a_sec_select: assert property (second_function_select_i |=> second_active_o)
      else $error("select did not give secondary times");
   a_freq_cap: assert property (current_frequency_o <= FRG_FREQ_MAX)
      else $error("frequency above maximum");
   a_rev_source: assert property ($changed(reverse_o) |-> reverse_o == $past(reverse_i))
      else $error("direction not taken from input");
endmodule : frg_ramp_checker
bind frg_ramp frg_ramp_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .start_i(start_i), .reverse_i(reverse_i),
   .second_function_select_i(second_function_select_i), .current_frequency_o(current_frequency_o),
   .reverse_o(reverse_o), .running_o(running_o), .second_active_o(second_active_o));
`default_nettype wire

// >>> verification/frg_motor_model.sv
// Purpose: Power stage and motor seen as a rotating field angle.
// Assumes: Frequency in 0.01 Hz units, one update per clock.
// Notes: The angle runs backwards in reverse rotation.
`timescale 1ns/1ps
`default_nettype none
module frg_motor_model (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [15:0] current_frequency_i,
   input wire logic reverse_i,
   input wire logic running_i,
   output logic [31:0] phase_o
);
   logic [31:0] phase_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_q <= 32'h0000_0000;
      end else if (running_i) begin
         phase_q <= reverse_i ? phase_q - {16'h0000, current_frequency_i} : phase_q + {16'h0000, current_frequency_i};
      end
   end
   assign phase_o = phase_q;
endmodule : frg_motor_model
`default_nettype wire

// >>> verification/tb_frequency_ramp_generator.sv
// Purpose: Self-checking bench of the ramp generator.
// Assumes: Short ramp tick of 100 clocks.
// Notes: Fine time increments keep ramps short.
`timescale 1ns/1ps
`default_nettype none
module tb_frequency_ramp_generator;
   import frg_pkg::*;
   localparam int LIMIT = 60000;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   frg_wb_req_t req = '0;
   logic start = 1'b0;
   logic dir = 1'b0;
   logic sel = 1'b0;
   logic ack, run, rev, sec;
   logic [31:0] rdat;
   logic [15:0] freq;
   logic [31:0] phase;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   frg_ramp #(.TICK_CYCLES(100)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_req_i(req),
      .wb_ack_o(ack), .wb_dat_o(rdat), .start_i(start), .reverse_i(dir), .second_function_select_i(sel),
      .current_frequency_o(freq), .reverse_o(rev), .running_o(run), .second_active_o(sec));
   frg_motor_model u_motor (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .current_frequency_i(freq),
      .reverse_i(rev), .running_i(run), .phase_o(phase));
   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
      do @(posedge core_clk_i); while (ack !== 1'b1);
      rd = rdat;
      req <= '0;
   endtask : wb
   task automatic wr(input logic [3:0] idx, input logic [15:0] v);
      logic [31:0] d;
      wb(1'b1, {2'b00, idx, 2'b00}, {16'h0000, v}, d);
   endtask : wr
   task automatic rd(input logic [3:0] idx, output logic [31:0] d);
      wb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, d);
   endtask : rd
   task automatic wait_step(input logic [15:0] old, input logic [15:0] exp);
      int n;
      n = 0;
      while (freq === old && n < 400) begin
         @(posedge core_clk_i);
         n++;
      end
      check("frequency", {16'h0000, exp}, {16'h0000, freq});
   endtask : wait_step
   task automatic go(input logic [15:0] exp);
      @(posedge core_clk_i);
      start <= 1'b1;
      @(posedge core_clk_i);
      #1;
      check("start frequency", {16'h0000, exp}, {16'h0000, freq});
   endtask : go
   task automatic halt;
      int n;
      start <= 1'b0;
      n = 0;
      while (run !== 1'b0 && n < 2000) begin
         @(posedge core_clk_i);
         n++;
      end
      check("stopped", 32'h0000_0000, {31'h0, run});
   endtask : halt
   task automatic t_regs;
      logic [31:0] d;
      rd(FRG_IDX_STARTF, d); check("start reset", 32'h0000_0032, d);
      rd(FRG_IDX_DEC2, d); check("decel2 reset", 32'h0000_270F, d);
      rd(FRG_IDX_SWF, d); check("switch reset", 32'h0000_270F, d);
      rd(FRG_IDX_REFF, d); check("ref reset", 32'h0000_1388, d);
      rd(FRG_IDX_CTRL, d); check("shape reset", 32'h0000_0000, d);
      for (int s = 0; s < 3; s++) begin
         wr(FRG_IDX_CTRL, 16'(s));
         rd(FRG_IDX_CTRL, d); check("shape", 32'(s), d);
      end
      wr(FRG_IDX_REFF, 16'h0000);
      rd(FRG_IDX_REFF, d); check("ref floor", 32'h0000_0064, d);
      wr(FRG_IDX_REFF, 16'h1388);
      wb(1'b1, 8'h3C, 32'h0000_FFFF, d);
      wb(1'b0, 8'h3C, 32'h0000_0000, d); check("unmapped", 32'h0000_0000, d);
      wb(1'b1, 8'h34, 32'h0000_FFFF, d);
      rd(FRG_IDX_STATUS, d); check("status", 32'h0000_0000, d);
      $display("test registers done");
   endtask : t_regs
   task automatic t_refuse;
      wr(FRG_IDX_SETF, 16'h001E);
      start <= 1'b1;
      repeat (300) @(posedge core_clk_i);
      check("refused run", 32'h0000_0000, {31'h0, run});
      start <= 1'b0;
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_linear;
      wr(FRG_IDX_CTRL, 16'h0004);
      wr(FRG_IDX_ACC1, 16'h0001);
      wr(FRG_IDX_ACC2, 16'h000A);
      wr(FRG_IDX_DEC1, 16'h0002);
      wr(FRG_IDX_SWF, 16'h01F4);
      wr(FRG_IDX_SETF, 16'h03E8);
      go(16'h0032);
      wait_step(16'h0032, 16'h00AF);
      wait_step(16'h00AF, 16'h012C);
      wait_step(16'h012C, 16'h01A9);
      wait_step(16'h01A9, 16'h0226);
      repeat (2) @(posedge core_clk_i);
      check("secondary on", 32'h0000_0001, {31'h0, sec});
      wait_step(16'h0226, 16'h0258);
      start <= 1'b0;
      wait_step(16'h0258, 16'h0226);
      wait_step(16'h0226, 16'h01F4);
      wait_step(16'h01F4, 16'h01C2);
      wait_step(16'h01C2, 16'h0145);
      halt();
      $display("test linear done");
   endtask : t_linear
   task automatic t_second;
      wr(FRG_IDX_SWF, 16'h270F);
      sel <= 1'b1;
      go(16'h0032);
      repeat (2) @(posedge core_clk_i);
      check("secondary select", 32'h0000_0001, {31'h0, sec});
      wait_step(16'h0032, 16'h0064);
      sel <= 1'b0;
      wait_step(16'h0064, 16'h00E1);
      check("secondary off", 32'h0000_0000, {31'h0, sec});
      halt();
      $display("test second done");
   endtask : t_second
   task automatic t_hold;
      wr(FRG_IDX_STARTF, 16'h0000);
      wr(FRG_IDX_HOLD, 16'h0001);
      go(16'h0001);
      repeat (300) @(posedge core_clk_i);
      check("held", 32'h0000_0001, {16'h0000, freq});
      halt();
      $display("test hold done");
   endtask : t_hold
   task automatic t_preset;
      wr(FRG_IDX_HOLD, 16'h270F);
      wr(FRG_IDX_SETF, 16'h0000);
      wr(FRG_IDX_PRESET, 16'h0064);
      go(16'h0000);
      check("preset run", 32'h0000_0001, {31'h0, run});
      wait_step(16'h0000, 16'h0064);
      halt();
      wr(FRG_IDX_SETF, 16'h03E8);
      $display("test preset done");
   endtask : t_preset
   task automatic t_reverse;
      logic [31:0] p;
      wr(FRG_IDX_STARTF, 16'h0032);
      go(16'h0032);
      wait_step(16'h0032, 16'h00AF);
      dir <= 1'b1;
      wait_step(16'h00AF, 16'h0032);
      @(posedge core_clk_i);
      check("direction", 32'h0000_0001, {31'h0, rev});
      p = phase;
      repeat (4) @(posedge core_clk_i);
      check("phase", p - 32'h0000_00C8, phase);
      wait_step(16'h0032, 16'h00AF);
      halt();
      dir <= 1'b0;
      $display("test reverse done");
   endtask : t_reverse
   task automatic t_shape_a;
      wr(FRG_IDX_STARTF, 16'h0186);
      wr(FRG_IDX_BASEF, 16'h0190);
      wr(FRG_IDX_ACC1, 16'h0004);
      wr(FRG_IDX_CTRL, 16'h0005);
      go(16'h0186);
      wait_step(16'h0186, 16'h0190);
      wait_step(16'h0190, 16'h019B);
      halt();
      $display("test shape a done");
   endtask : t_shape_a
   task automatic t_shape_b;
      wr(FRG_IDX_CTRL, 16'h0006);
      wr(FRG_IDX_ACC1, 16'h0005);
      wr(FRG_IDX_SETF, 16'h03DE);
      go(16'h0186);
      wait_step(16'h0186, 16'h019F);
      wait_step(16'h019F, 16'h01C0);
      halt();
      $display("test shape b done");
   endtask : t_shape_b
   initial begin
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      t_regs();
      t_refuse();
      t_linear();
      t_second();
      t_hold();
      t_preset();
      t_reverse();
      t_shape_a();
      t_shape_b();
      stop_test();
   end
endmodule : tb_frequency_ramp_generator
`default_nettype wire
